// File: core/sit_spi_transfer.sv
// serial interface unit: spi transfer, flags, and i2c slave pin logic
// Functional notes
// - write collision flag reports a collision on the data register
// - transfer end sets complete flag; software clears it
// - master enabled: data write starts full duplex transfer at once
// - slave: external clock shifts data out and input into same register
// - slave output follows data write; floats while select is high
// - slave with select pin disabled is always selected
// - select pin enable bit enables select input, else pin floats
// - keeps working in idle modes while its clock runs
// - i2c drivers are open drain, pull low or release
// - i2c has no select line; recognised by bus address only
// - i2c acts only as slave, receives the address byte and acks a match, sends no data
// - pull-up control stays with its own register in i2c mode
// - mode field selects master rates, slave 101, i2c 110
// - interface disabled floats all lines, minimal activity
// - polarity bit high idles clock low, low idles high
`timescale 1ns/100ps
`default_nettype none
module sit_spi_transfer (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// configuration
	input wire logic [2:0] operatingModeField,
	input wire logic interfaceEnableBit,
	input wire logic selectPinEnableBit,
	input wire logic clockPolarityBit,
	input wire logic clockEdgeBit,
	input wire logic msbFirst,
	input wire logic [6:0] slaveAddress,
	input wire logic pullUpEnable,
	input wire logic subTick,
	input wire logic tmrTick,
	// data register access
	input wire logic dataWrite,
	input wire logic [7:0] dataIn,
	output logic [7:0] serialDataRegister,
	// flag clears
	input wire logic clearCollision,
	input wire logic clearComplete,
	// flags
	output logic writeCollisionFlag,
	output logic transferCompleteFlag,
	output logic irqReq,
	output logic busy,
	output logic i2cAddressed,
	// spi pins
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe,
	input wire logic sdi,
	output logic sdo,
	output logic sdoOe,
	input wire logic slave_select_n,
	// i2c pins
	input wire logic sdaIn,
	output logic sdaOe,
	input wire logic sclIn,
	output logic sclOe,
	output logic pullUpOn
);
	sit_pkg::sit_state_t state_ff, nxt_state;
	logic [7:0] shReg_ff, nxt_shReg;
	logic [3:0] bitCnt_ff, nxt_bitCnt;
	logic sck_ff, nxt_sck;
	logic sdo_ff, nxt_sdo;
	logic write_collision_flag_ff, nxt_write_collision_flag;
	logic trf_ff, nxt_trf;
	logic irq_ff, nxt_irq;
	logic sckIn_ff, nxt_sckIn;
	logic sclPrev_ff, nxt_sclPrev;
	logic sdaPrev_ff, nxt_sdaPrev;
	logic sdaOe_ff, nxt_sdaOe;
	logic addrHit_ff, nxt_addrHit;
	logic [3:0] i2cCnt_ff, nxt_i2cCnt;
	logic [7:0] i2cSh_ff, nxt_i2cSh;
	logic i2cActive_ff, nxt_i2cActive;

	logic isMaster, isSlave, isI2c, selected, halfTick, inEdge, outEdge, sckRise, sckFall, sclRise, sclFall;
	logic idleLevel;

	function automatic logic outBit(input logic [7:0] d, input logic msb);
		outBit = msb ? d[7] : d[0];
	endfunction

	function automatic logic [7:0] shiftIn(input logic [7:0] d, input logic b, input logic msb);
		shiftIn = msb ? {d[6:0], b} : {b, d[7:1]};
	endfunction

	sit_clk_gen uClkGen (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(state_ff == sit_pkg::SIT_SHIFT && isMaster),
		.mode(operatingModeField),
		.subTick(subTick),
		.tmrTick(tmrTick),
		.halfTick(halfTick)
	);

	// =========================================
	// mode decode
	always_comb begin
		isMaster = interfaceEnableBit && (operatingModeField <= sit_pkg::MODE_TMR);
		isSlave = interfaceEnableBit && (operatingModeField == sit_pkg::MODE_SLAVE);
		isI2c = interfaceEnableBit && (operatingModeField == sit_pkg::MODE_I2C);
		selected = !selectPinEnableBit || !slave_select_n;
		idleLevel = !clockPolarityBit;
		sckRise = sckIn && !sckIn_ff;
		sckFall = !sckIn && sckIn_ff;
		// sample edge: leaving idle when edge bit set, otherwise returning
		inEdge = (clockEdgeBit ^ idleLevel) ? sckRise : sckFall;
		outEdge = (clockEdgeBit ^ idleLevel) ? sckFall : sckRise;
		sclRise = sclIn && !sclPrev_ff;
		sclFall = !sclIn && sclPrev_ff;
	end

	// =========================================
	// spi transfer engine
	always_comb begin
		nxt_state = state_ff;
		nxt_shReg = shReg_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_sck = sck_ff;
		nxt_sdo = sdo_ff;
		nxt_write_collision_flag = write_collision_flag_ff;
		nxt_trf = trf_ff;
		nxt_irq = 1'b0;
		nxt_sckIn = sckIn;
		if (clearCollision)
			nxt_write_collision_flag = 1'b0;
		if (clearComplete)
			nxt_trf = 1'b0;
		case (state_ff)
			sit_pkg::SIT_IDLE: begin
				nxt_sck = idleLevel;
				if (dataWrite && (isMaster || isSlave)) begin
					nxt_shReg = dataIn;
					nxt_sdo = outBit(dataIn, msbFirst);
					nxt_bitCnt = 4'h0;
					if (isMaster)
						nxt_state = sit_pkg::SIT_SHIFT;
				end
				if (isSlave && selected && (inEdge || outEdge))
					nxt_state = sit_pkg::SIT_SHIFT;
				if (isSlave && selected && inEdge) begin
					nxt_shReg = shiftIn(shReg_ff, sdi, msbFirst);
					nxt_bitCnt = 4'h1;
				end
			end
			sit_pkg::SIT_SHIFT: begin
				if (dataWrite)
					nxt_write_collision_flag = 1'b1;
				if (isMaster) begin
					if (halfTick) begin
						nxt_sck = ~sck_ff;
						if (sck_ff == idleLevel) begin
							// leading edge
							if (clockEdgeBit) begin
								nxt_shReg = shiftIn(shReg_ff, sdi, msbFirst);
								nxt_bitCnt = bitCnt_ff + 4'h1;
							end else if (bitCnt_ff != 4'h0) begin
								nxt_sdo = outBit(shReg_ff, msbFirst);
							end
						end else begin
							if (clockEdgeBit) begin
								nxt_sdo = outBit(shReg_ff, msbFirst);
							end else begin
								nxt_shReg = shiftIn(shReg_ff, sdi, msbFirst);
								nxt_bitCnt = bitCnt_ff + 4'h1;
							end
							if (bitCnt_ff == sit_pkg::BIT_COUNT || (!clockEdgeBit &&
								bitCnt_ff == sit_pkg::BIT_COUNT - 4'h1))
								nxt_state = sit_pkg::SIT_DONE;
						end
					end
				end else if (isSlave) begin
					if (selected && inEdge) begin
						nxt_shReg = shiftIn(shReg_ff, sdi, msbFirst);
						nxt_bitCnt = bitCnt_ff + 4'h1;
						if (bitCnt_ff == sit_pkg::BIT_COUNT - 4'h1)
							nxt_state = sit_pkg::SIT_DONE;
					end else if (selected && outEdge) begin
						nxt_sdo = outBit(shReg_ff, msbFirst);
					end
				end else begin
					nxt_state = sit_pkg::SIT_IDLE;
				end
			end
			sit_pkg::SIT_DONE: begin
				// still busy: a write here is a collision too
				if (dataWrite)
					nxt_write_collision_flag = 1'b1;
				nxt_trf = 1'b1;
				nxt_irq = 1'b1;
				nxt_sck = idleLevel;
				nxt_state = sit_pkg::SIT_IDLE;
			end
			default: nxt_state = sit_pkg::SIT_IDLE;
		endcase
		if (!interfaceEnableBit)
			nxt_state = sit_pkg::SIT_IDLE;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= sit_pkg::SIT_IDLE;
			shReg_ff <= sit_pkg::DATA_RST;
			bitCnt_ff <= 4'h0;
			sck_ff <= 1'b1;
			sdo_ff <= 1'b0;
			write_collision_flag_ff <= 1'b0;
			trf_ff <= 1'b0;
			irq_ff <= 1'b0;
			sckIn_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			shReg_ff <= nxt_shReg;
			bitCnt_ff <= nxt_bitCnt;
			sck_ff <= nxt_sck;
			sdo_ff <= nxt_sdo;
			write_collision_flag_ff <= nxt_write_collision_flag;
			trf_ff <= nxt_trf;
			irq_ff <= nxt_irq;
			sckIn_ff <= nxt_sckIn;
		end
	end

	// =========================================
	// i2c slave pin logic
	always_comb begin
		nxt_sclPrev = sclIn;
		nxt_sdaPrev = sdaIn;
		nxt_sdaOe = sdaOe_ff;
		nxt_addrHit = addrHit_ff;
		nxt_i2cCnt = i2cCnt_ff;
		nxt_i2cSh = i2cSh_ff;
		nxt_i2cActive = i2cActive_ff;
		if (!isI2c) begin
			nxt_sdaOe = 1'b0;
			nxt_addrHit = 1'b0;
			nxt_i2cActive = 1'b0;
		end else if (sclIn && sdaPrev_ff && !sdaIn) begin
			// start condition
			nxt_i2cActive = 1'b1;
			nxt_addrHit = 1'b0;
			nxt_i2cCnt = 4'h0;
			nxt_sdaOe = 1'b0;
		end else if (sclIn && !sdaPrev_ff && sdaIn) begin
			nxt_i2cActive = 1'b0;
			nxt_addrHit = 1'b0;
			nxt_sdaOe = 1'b0;
		end else if (i2cActive_ff && sclRise && i2cCnt_ff < sit_pkg::BIT_COUNT) begin
			nxt_i2cSh = {i2cSh_ff[6:0], sdaIn};
			nxt_i2cCnt = i2cCnt_ff + 4'h1;
		end else if (i2cActive_ff && sclFall) begin
			if (i2cCnt_ff == sit_pkg::BIT_COUNT && i2cSh_ff[7:1] == slaveAddress) begin
				nxt_addrHit = 1'b1;
				nxt_sdaOe = 1'b1;
				nxt_i2cCnt = i2cCnt_ff + 4'h1;
			end else if (i2cCnt_ff > sit_pkg::BIT_COUNT) begin
				nxt_sdaOe = 1'b0;
				nxt_i2cCnt = 4'h0;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclPrev_ff <= 1'b1;
			sdaPrev_ff <= 1'b1;
			sdaOe_ff <= 1'b0;
			addrHit_ff <= 1'b0;
			i2cCnt_ff <= 4'h0;
			i2cSh_ff <= 8'h00;
			i2cActive_ff <= 1'b0;
		end else begin
			sclPrev_ff <= nxt_sclPrev;
			sdaPrev_ff <= nxt_sdaPrev;
			sdaOe_ff <= nxt_sdaOe;
			addrHit_ff <= nxt_addrHit;
			i2cCnt_ff <= nxt_i2cCnt;
			i2cSh_ff <= nxt_i2cSh;
			i2cActive_ff <= nxt_i2cActive;
		end
	end

	// =========================================
	// outputs
	assign serialDataRegister = shReg_ff;
	assign writeCollisionFlag = write_collision_flag_ff;
	assign transferCompleteFlag = trf_ff;
	assign irqReq = irq_ff;
	assign busy = (state_ff != sit_pkg::SIT_IDLE);
	assign i2cAddressed = addrHit_ff;
	assign sckOut = sck_ff;
	assign sckOe = isMaster;
	assign sdo = sdo_ff;
	assign sdoOe = isMaster || (isSlave && selected);
	assign sdaOe = sdaOe_ff && isI2c;
	assign sclOe = 1'b0;
	assign pullUpOn = pullUpEnable;
endmodule
`default_nettype wire

// File: core/sit_pkg.sv
// constants and types for the serial interface transfer block
package sit_pkg;
	// operating mode field codes
	localparam logic [2:0] MODE_DIV4 = 3'h0;
	localparam logic [2:0] MODE_DIV16 = 3'h1;
	localparam logic [2:0] MODE_DIV64 = 3'h2;
	localparam logic [2:0] MODE_SUB = 3'h3;
	localparam logic [2:0] MODE_TMR = 3'h4;
	localparam logic [2:0] MODE_SLAVE = 3'h5;
	localparam logic [2:0] MODE_I2C = 3'h6;
	// reset values
	localparam logic [2:0] MODE_RST = 3'h7;
	localparam logic [7:0] DATA_RST = 8'h00;
	// divider half periods minus one, in system clocks; then bits per frame and a default i2c address
	localparam logic [5:0] HALF_DIV4 = 6'h01;
	localparam logic [5:0] HALF_DIV16 = 6'h07;
	localparam logic [5:0] HALF_DIV64 = 6'h1f;
	localparam logic [3:0] BIT_COUNT = 4'h8;
	localparam logic [7:0] I2C_ADDR_DEFAULT = 8'h50;
	typedef enum logic [1:0] {
		SIT_IDLE = 2'b00,
		SIT_SHIFT = 2'b01,
		SIT_DONE = 2'b11
	} sit_state_t;
endpackage

// File: core/sit_clk_gen.sv
// master serial clock edge generator
`timescale 1ns/100ps
`default_nettype none
module sit_clk_gen (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic run,
	input wire logic [2:0] mode,
	input wire logic subTick,
	input wire logic tmrTick,
	// half period enable
	output logic halfTick
);
	logic [5:0] cnt_ff;
	logic [5:0] nxt_cnt;
	logic tmrDiv_ff;
	logic nxt_tmrDiv;
	logic [5:0] limit;

	always_comb begin
		limit = sit_pkg::HALF_DIV4;
		nxt_cnt = cnt_ff;
		nxt_tmrDiv = tmrDiv_ff;
		halfTick = 1'b0;
		case (mode)
			sit_pkg::MODE_DIV16: limit = sit_pkg::HALF_DIV16;
			sit_pkg::MODE_DIV64: limit = sit_pkg::HALF_DIV64;
			default: limit = sit_pkg::HALF_DIV4;
		endcase
		if (!run) begin
			nxt_cnt = 6'h00;
			nxt_tmrDiv = 1'b0;
		end else if (mode == sit_pkg::MODE_SUB) begin
			halfTick = subTick;
		end else if (mode == sit_pkg::MODE_TMR) begin
			// match rate halved
			if (tmrTick) begin
				nxt_tmrDiv = ~tmrDiv_ff;
				halfTick = tmrDiv_ff;
			end
		end else if (cnt_ff >= limit) begin
			nxt_cnt = 6'h00;
			halfTick = 1'b1;
		end else begin
			nxt_cnt = cnt_ff + 6'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= 6'h00;
			tmrDiv_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tmrDiv_ff <= nxt_tmrDiv;
		end
	end
endmodule
`default_nettype wire

// File: bench/sit_spi_transfer_sva.sv
// checker for the spi transfer block
`timescale 1ns/100ps
`default_nettype none
module sit_spi_transfer_sva (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// controls
	input wire logic [2:0] operatingModeField,
	input wire logic interfaceEnableBit,
	input wire logic selectPinEnableBit,
	input wire logic clockPolarityBit,
	input wire logic dataWrite,
	input wire logic clearComplete,
	input wire logic slave_select_n,
	// results
	input wire logic writeCollisionFlag,
	input wire logic transferCompleteFlag,
	input wire logic irqReq,
	input wire logic busy,
	input wire logic sckOut,
	input wire logic sckOe,
	input wire logic sdoOe
);
	logic mst;
	logic slv;
	assign mst = interfaceEnableBit && operatingModeField < sit_pkg::MODE_SLAVE;
	assign slv = interfaceEnableBit && operatingModeField == sit_pkg::MODE_SLAVE;
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// =====
	// flags and start
	a_write_collision_flag_set: assert property (busy && dataWrite |=> writeCollisionFlag)
		else $error("collision flag missed");
	a_trf_hold: assert property (transferCompleteFlag && !clearComplete |=> transferCompleteFlag)
		else $error("complete flag lost");
	a_irq_pulse: assert property ($rose(transferCompleteFlag) |-> irqReq ##1 !irqReq)
		else $error("bad interrupt pulse");
	a_master_start: assert property (mst && !busy && dataWrite |=> busy)
		else $error("master write did not start");
	// =====
	// pins
	a_sel_float: assert property ((slv && selectPinEnableBit && slave_select_n)[*3] |-> !sdoOe)
		else $error("output driven while deselected");
	a_always_sel: assert property (slv && !selectPinEnableBit |-> sdoOe)
		else $error("output not driven");
	a_off_float: assert property (!interfaceEnableBit |-> !sckOe && !sdoOe)
		else $error("pins driven while disabled");
	a_sck_drive: assert property (sckOe == mst)
		else $error("clock drive wrong for mode");
	a_idle_level: assert property ((mst && !busy && $stable(clockPolarityBit))[*3] |-> sckOut == !clockPolarityBit)
		else $error("clock idle level wrong");
endmodule
bind sit_spi_transfer sit_spi_transfer_sva sit_spi_transfer_sva_i (.clk, .sys_rst, .operatingModeField,
	.interfaceEnableBit, .selectPinEnableBit, .clockPolarityBit, .dataWrite, .clearComplete, .slave_select_n,
	.writeCollisionFlag, .transferCompleteFlag, .irqReq, .busy, .sckOut, .sckOe, .sdoOe);
`default_nettype wire

// File: bench/sit_spi_partner.sv
// far side model: echoing slave, or a slow external master
`timescale 1ns/100ps
`default_nettype none
module sit_spi_partner (
	// clock
	input wire logic clk,
	// far side inputs
	input wire logic loopBack,
	input wire logic sdo,
	// far side outputs
	output logic sckIn,
	output logic sdi,
	output logic slave_select_n
);
	logic freeBit;
	logic dataBit;
	logic frameOn;
	initial begin
		sckIn = 1'h0;
		slave_select_n = 1'h1;
		freeBit = 1'h0;
		dataBit = 1'h0;
		frameOn = 1'h0;
	end
	// outside frames the line wanders so stale bits cannot pass
	always @(posedge clk) freeBit <= ~freeBit;
	always_comb sdi = loopBack ? sdo : (frameOn ? dataBit : freeBit);
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		@(posedge clk);
		slave_select_n <= 1'h0;
		frameOn <= 1'h1;
		for (int i = 7; i >= 0; i--) begin
			dataBit <= tx[i];
			repeat (8) @(posedge clk);
			sckIn <= 1'h1;
			rx[i] = sdo;
			repeat (8) @(posedge clk);
			sckIn <= 1'h0;
		end
		repeat (8) @(posedge clk);
		slave_select_n <= 1'h1;
		frameOn <= 1'h0;
	endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the spi transfer block
`timescale 1ns/100ps
`default_nettype none
module tb;
	typedef struct {logic [2:0] m; logic p; logic [7:0] d; int len; logic chk;} sit_row_t;
	logic clk, sys_rst, interfaceEnableBit, selectPinEnableBit, clockPolarityBit, pullUpEnable;
	logic subTick, tmrTick, dataWrite, clearCollision, clearComplete, sckIn, sdi, slave_select_n;
	logic writeCollisionFlag, transferCompleteFlag, irqReq, busy, i2cAddressed, sckOut, sckOe;
	logic sdo, sdoOe, sdaOe, sclOe, pullUpOn, sdaIn, sclIn;
	logic [7:0] i2cByte;
	logic [2:0] operatingModeField;
	logic [7:0] dataIn, serialDataRegister, rx;
	logic [3:0] tick;
	int err_count, n_compared, n;
	sit_row_t rows [5] = '{
		'{sit_pkg::MODE_DIV4, 1'h1, 8'hA5, 16 * (sit_pkg::HALF_DIV4 + 1), 1'h0},
		'{sit_pkg::MODE_DIV16, 1'h0, 8'h3C, 16 * (sit_pkg::HALF_DIV16 + 1), 1'h1},
		'{sit_pkg::MODE_DIV64, 1'h1, 8'h81, 16 * (sit_pkg::HALF_DIV64 + 1), 1'h1},
		'{sit_pkg::MODE_SUB, 1'h0, 8'h7E, 0, 1'h1},
		'{sit_pkg::MODE_TMR, 1'h1, 8'h42, 0, 1'h1}};
	sit_spi_transfer sit_spi_transfer_i (.clk, .sys_rst, .operatingModeField, .interfaceEnableBit,
		.selectPinEnableBit, .clockPolarityBit, .clockEdgeBit(1'h1), .msbFirst(1'h1), .slaveAddress(7'h2A),
		.pullUpEnable, .subTick, .tmrTick, .dataWrite, .dataIn, .serialDataRegister, .clearCollision,
		.clearComplete, .writeCollisionFlag, .transferCompleteFlag, .irqReq, .busy, .i2cAddressed, .sckIn,
		.sckOut, .sckOe, .sdi, .sdo, .sdoOe, .slave_select_n, .sdaIn, .sdaOe, .sclIn, .sclOe,
		.pullUpOn);
	sit_spi_partner sit_spi_partner_i (.clk, .loopBack(operatingModeField < sit_pkg::MODE_SLAVE), .sdo,
		.sckIn, .sdi, .slave_select_n);
	always #10 clk = ~clk;
	always @(posedge clk) begin
		tick <= tick + 4'h1;
		subTick <= tick[1:0] == 2'h0;
		tmrTick <= tick[1:0] == 2'h2;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] d);
		dataIn <= d;
		dataWrite <= 1'h1;
		@(posedge clk);
		dataWrite <= 1'h0;
	endtask
	task automatic clr();
		clearCollision <= 1'h1;
		clearComplete <= 1'h1;
		@(posedge clk);
		clearCollision <= 1'h0;
		clearComplete <= 1'h0;
		@(negedge clk);
	endtask
	task automatic wait_done();
		n = 0;
		while (transferCompleteFlag !== 1'h1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// whole run is near 1300 cycles
	initial begin
		#100000;
		err_count++;
		finish_test();
	end
	initial begin
		clk = 1'h0;
		sys_rst = 1'h1;
		tick = 4'h0;
		{subTick, tmrTick, dataWrite, clearCollision, clearComplete, pullUpEnable} = 6'h00;
		{interfaceEnableBit, selectPinEnableBit, clockPolarityBit} = 3'h7;
		operatingModeField = sit_pkg::MODE_DIV4;
		dataIn = 8'h00;
		sdaIn = 1'h1;
		sclIn = 1'h1;
		i2cByte = {7'h2A, 1'h0};
		repeat (5) @(posedge clk);
		sys_rst <= 1'h0;
		@(negedge clk);
		check("flags", {writeCollisionFlag, transferCompleteFlag, busy}, 3'h0);
		check("data", serialDataRegister, sit_pkg::DATA_RST);
		foreach (rows[i]) begin
			operatingModeField <= rows[i].m;
			clockPolarityBit <= rows[i].p;
			repeat (3) @(negedge clk);
			wr(rows[i].d);
			wait_done();
			check("done", transferCompleteFlag, 1'h1);
			if (rows[i].len > 0) check("len", n >= rows[i].len && n <= rows[i].len + 8, 1'h1);
			if (rows[i].chk) check("loop", serialDataRegister, rows[i].d);
			clr();
			check("clear", transferCompleteFlag, 1'h0);
		end
		operatingModeField <= sit_pkg::MODE_DIV16;
		wr(8'hC3);
		repeat (10) @(posedge clk);
		wr(8'h18);
		wait_done();
		check("write_collision_flag", writeCollisionFlag, 1'h1);
		check("kept", serialDataRegister, 8'hC3);
		clr();
		check("wcolclr", writeCollisionFlag, 1'h0);
		interfaceEnableBit <= 1'h0;
		wr(8'h99);
		@(negedge clk);
		check("off", {busy, sckOe, sdoOe}, 3'h0);
		interfaceEnableBit <= 1'h1;
		operatingModeField <= sit_pkg::MODE_SLAVE;
		// slave data is loaded before select falls
		wr(8'hA5);
		repeat (3) @(negedge clk);
		check("sdo", {sdo, sdoOe}, 2'h2);
		sit_spi_partner_i.xfer(8'h3C, rx);
		wait_done();
		check("srx", serialDataRegister, 8'h3C);
		check("stx", rx, 8'hA5);
		selectPinEnableBit <= 1'h0;
		clr();
		check("sel", sdoOe, 1'h1);
		operatingModeField <= sit_pkg::MODE_I2C;
		pullUpEnable <= 1'h1;
		repeat (4) @(negedge clk);
		check("i2c", {sdaOe, sclOe, i2cAddressed, pullUpOn}, 4'h1);
		// start condition, then own address with write bit
		@(posedge clk);
		sdaIn <= 1'h0;
		repeat (4) @(posedge clk);
		for (int i = 7; i >= 0; i--) begin
			sclIn <= 1'h0;
			repeat (2) @(posedge clk);
			sdaIn <= i2cByte[i];
			repeat (2) @(posedge clk);
			sclIn <= 1'h1;
			repeat (4) @(posedge clk);
		end
		sclIn <= 1'h0;
		repeat (3) @(negedge clk);
		check("i2cack", {sdaOe, i2cAddressed}, 2'h3);
		check("i2cscl", sclOe, 1'h0);
		finish_test();
	end
endmodule
`default_nettype wire
